// *** ubrk_pkg.sv ***
// package: register map, field layout and constants of the break field and baud generator block
package ubrk_pkg;
    // register addresses (word index on the plain port)
    localparam logic [3:0] ADDR_MODE    = 4'h0;  // operation_mode_reg
    localparam logic [3:0] ADDR_BRKCTL  = 4'h1;  // break_control_reg
    localparam logic [3:0] ADDR_CKSEL   = 4'h2;  // clock_select_reg
    localparam logic [3:0] ADDR_DIV     = 4'h3;  // baud_divider_reg
    localparam logic [3:0] ADDR_TXBUF   = 4'h4;  // tx_buffer_reg (write only)
    localparam logic [3:0] ADDR_RXBUF   = 4'h5;  // rx_buffer_reg
    localparam logic [3:0] ADDR_ERRSTAT = 4'h6;  // rx_error_status_reg
    // operation mode fields
    localparam int MODE_POWER_BIT = 7;
    localparam int MODE_TXE_BIT   = 6;
    localparam int MODE_RXE_BIT   = 5;
    localparam int MODE_MERGE_BIT = 0;
    // break control fields
    localparam int BRK_FLAG_BIT   = 7;
    localparam int BRK_RXEN_BIT   = 6;
    localparam int BRK_SEND_BIT   = 5;
    localparam int BRK_LEN_LSB    = 2;
    localparam int BRK_LEN_W      = 3;
    // error status fields
    localparam int ERR_OVE_BIT    = 0;
    localparam int ERR_PE_BIT     = 1;
    localparam int ERR_FE_BIT     = 2;
    // field widths
    localparam int PRESCALE_W     = 4;
    localparam int DIV_W          = 8;
    // reset values
    localparam logic [7:0] MODE_RST   = 8'h01;
    localparam logic [7:0] BRKCTL_RST = 8'h00;
    localparam logic [3:0] CKSEL_RST  = 4'h0;
    localparam logic [7:0] DIV_RST    = 8'hFF;
    localparam logic [7:0] RXBUF_RST  = 8'hFF;
    // break timing in bits and half bits, divider minimum, prescaler width, frame length in bits
    localparam logic [4:0] BRK_TX_MIN_BITS = 5'd13;
    localparam logic [4:0] BRK_VALID_HALF  = 5'd21;  // 10.5 bits in half bit units
    localparam logic [7:0] DIV_MIN         = 8'h04;
    localparam int         PRESCALE_MAX    = 10;
    localparam int         FRAME_BITS      = 10;      // start, 8 data, stop
endpackage : ubrk_pkg

// *** ubrk_prescaler.sv ***
// base clock prescaler: one enable pulse per selected base clock period
`timescale 1ns/1ps
module ubrk_prescaler
    import ubrk_pkg::*;
(
    // clock and reset
    input  wire logic                  mclk_i,
    input  wire logic                  sys_rst_i,
    // control
    input  wire logic                  power_i,
    input  wire logic [PRESCALE_W-1:0] sel_i,
    // base clock tick
    output logic                       tick_o
);
    typedef struct packed {
        logic [PRESCALE_MAX-1:0] cnt;
        logic                    tick;
    } ubrk_ps_t;
    ubrk_ps_t s_q, s_d;

    // power low holds the divider and base tick at zero
    always_comb begin
        logic [PRESCALE_MAX-1:0] mask;
        mask = '0;
        s_d = s_q;
        for (int i = 0; i < PRESCALE_MAX; i++) begin
            if (i < int'(sel_i)) mask[i] = 1'b1;
        end
        if (!power_i) begin
            s_d.cnt  = '0;
            s_d.tick = 1'b0;
        end else begin
            s_d.tick = ((s_q.cnt & mask) == mask);
            s_d.cnt  = s_q.cnt + 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) s_q <= '0;
        else           s_q <= s_d;
    end

    assign tick_o = s_q.tick;
endmodule : ubrk_prescaler

// *** ubrk_core.sv ***
// break field transmit/receive, noise filter, baud counters and register file
// Functional notes
// - merge select 0 gives separate error irq; 1 routes errors to rx done irq
// - serial input sampled on base clock; level changes when two samples agree
// - receive logic sees the input two base clocks after the pin; code takes two mclk sync stages plus three base clocks
// - power enable set drives the serial output high when idle
// - power, then tx enable, then break send trigger starts a break
// - break output low for 13 to 20 bit times per length field
// - break end pulses tx done irq, clears send trigger, resumes normal mode
// - after a break the transmitter idles until buffer write or new trigger
// - break receive enable with power and rx enable enters break reception
// - break of 11 bits or more raises rx done, clears flag and enable
// - overrun, parity and framing flags are not set in break reception
// - rx buffer is not loaded during break reception, keeps all ones
// - break of 10 bits or less raises nothing, stays in break mode
// - break valid only when low longer than 10.5 bits
// - base clock from prescale select, runs only with power enable
// - two independent 8-bit counters, transmit and receive
// - tx counter held at zero unless power and tx enable both set
// - tx counter cleared on first buffer write and at each frame end; code clears it at frame end only with a byte pending
// - rx counter held at zero unless enabled; runs start bit to frame end
// - divider field sets the division ratio, range 4 to 255
// - bit rate equals base clock over twice the divider
// - merge select is bit 0 of the operation mode register
`timescale 1ns/1ps
module ubrk_core
    import ubrk_pkg::*;
#(
    parameter int DIV_WIDTH = DIV_W
) (
    // clock and reset
    input  wire logic       mclk_i,
    input  wire logic       sys_rst_i,
    // register port
    input  wire logic [3:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic [7:0]      reg_rdata_o,
    // serial pins
    input  wire logic       serial_in_pin_i,
    output logic            serial_out_pin_o,
    // interrupts
    output logic            tx_done_irq_o,
    output logic            rx_done_irq_o,
    output logic            rx_error_irq_o
);
    import ubrk_pkg::*;

    typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_BREAK} ubrk_tx_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_BRK} ubrk_rx_t;

    typedef struct packed {
        logic [7:0]           mode;
        logic [7:0]           brkctl;
        logic [3:0]           cksel;
        logic [DIV_WIDTH-1:0] div;
        logic [7:0]           rxbuf;
        logic                 rxbuf_full;
        logic [2:0]           err;
        logic [1:0]           pin_sync;
        logic [1:0]           samp;
        logic                 filt;
        ubrk_tx_t             tx_st;
        logic [DIV_WIDTH-1:0] tx_cnt;
        logic                 tx_half;
        logic [4:0]           tx_bits;
        logic [9:0]           tx_shift;
        logic                 tx_pend;
        logic [7:0]           tx_hold;
        logic                 tx_out;
        ubrk_rx_t             rx_st;
        logic [DIV_WIDTH-1:0] rx_cnt;
        logic                 rx_half;
        logic [3:0]           rx_bits;
        logic [7:0]           rx_shift;
        logic [5:0]           rx_low;
        logic                 tx_irq;
        logic                 rx_irq;
        logic                 err_irq;
        logic [7:0]           rdata;
    } ubrk_st_t;

    ubrk_st_t s_q, s_d;
    logic     base_tick;
    logic     power, txe, rxe;

    // base clock generation
    ubrk_prescaler u_prescaler (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .power_i   (power),
        .sel_i     (s_q.cksel),
        .tick_o    (base_tick)
    );

    assign power = s_q.mode[MODE_POWER_BIT];
    assign txe   = s_q.mode[MODE_TXE_BIT];
    assign rxe   = s_q.mode[MODE_RXE_BIT];

    // one baud counter step: returns 1 on half bit boundary (k base ticks)
    function automatic logic half_done(input logic [DIV_WIDTH-1:0] cnt,
                                       input logic [DIV_WIDTH-1:0] k);
        logic [DIV_WIDTH-1:0] lim;
        lim = (k < DIV_WIDTH'(DIV_MIN)) ? DIV_WIDTH'(DIV_MIN) : k;
        half_done = (cnt == lim - 1'b1);
    endfunction : half_done

    always_comb begin
        logic tx_wr, brk_trig, rx_bit_mid;
        logic [4:0] brk_len;
        s_d = s_q;
        tx_wr      = 1'b0;
        brk_trig   = 1'b0;
        rx_bit_mid = 1'b0;
        brk_len    = BRK_TX_MIN_BITS + 5'(s_q.brkctl[BRK_LEN_LSB +: BRK_LEN_W]);
        s_d.tx_irq  = 1'b0;
        s_d.rx_irq  = 1'b0;
        s_d.err_irq = 1'b0;
        s_d.rdata   = 8'h00;

        // register writes and reads
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                ADDR_MODE:   s_d.mode   = reg_wdata_i;
                ADDR_BRKCTL: begin
                    s_d.brkctl[BRK_LEN_LSB +: BRK_LEN_W] = reg_wdata_i[BRK_LEN_LSB +: BRK_LEN_W];
                    if (reg_wdata_i[BRK_SEND_BIT] && power && txe) brk_trig = 1'b1;
                    if (reg_wdata_i[BRK_RXEN_BIT] && power && rxe) begin
                        s_d.brkctl[BRK_RXEN_BIT] = 1'b1;
                        s_d.brkctl[BRK_FLAG_BIT] = 1'b1;
                    end
                end
                ADDR_CKSEL:  s_d.cksel  = reg_wdata_i[PRESCALE_W-1:0];
                ADDR_DIV:    s_d.div    = reg_wdata_i[DIV_WIDTH-1:0];
                ADDR_TXBUF:  tx_wr      = power && txe;
                default: ;
            endcase
        end
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                ADDR_MODE:    s_d.rdata = s_q.mode;
                ADDR_BRKCTL:  s_d.rdata = s_q.brkctl;
                ADDR_CKSEL:   s_d.rdata = {4'h0, s_q.cksel};
                ADDR_DIV:     s_d.rdata = s_q.div;
                ADDR_RXBUF: begin
                    s_d.rdata      = s_q.rxbuf;
                    s_d.rxbuf_full = 1'b0;
                end
                ADDR_ERRSTAT: begin
                    s_d.rdata = {5'h00, s_q.err};
                    s_d.err   = 3'b000;  // cleared by read
                end
                default:      s_d.rdata = 8'h00;
            endcase
        end
        if (brk_trig) s_d.brkctl[BRK_SEND_BIT] = 1'b1;

        // input sync then two-sample match filter on base clock
        s_d.pin_sync = {s_q.pin_sync[0], serial_in_pin_i};
        if (base_tick) begin
            s_d.samp = {s_q.samp[0], s_q.pin_sync[1]};
            if (s_q.samp[0] == s_q.samp[1]) s_d.filt = s_q.samp[1];
        end

        // transmitter: counter runs on base ticks, one half bit per k ticks
        if (tx_wr) begin
            s_d.tx_hold = reg_wdata_i;
            s_d.tx_pend = 1'b1;
        end
        if (!power || !txe) begin
            s_d.tx_cnt  = '0;
            s_d.tx_half = 1'b0;
            s_d.tx_st   = TX_IDLE;
            s_d.tx_pend = 1'b0;
            s_d.tx_out  = 1'b1;
            s_d.brkctl[BRK_SEND_BIT] = 1'b0;
        end else begin
            if (base_tick) begin
                if (half_done(s_q.tx_cnt, s_q.div)) begin
                    s_d.tx_cnt  = '0;
                    s_d.tx_half = ~s_q.tx_half;
                end else begin
                    s_d.tx_cnt = s_q.tx_cnt + 1'b1;
                end
            end
            unique case (s_q.tx_st)
                TX_IDLE: begin
                    s_d.tx_out = 1'b1;
                    // start on a base tick so the low spans whole bit times
                    if (s_q.brkctl[BRK_SEND_BIT] && base_tick) begin
                        s_d.tx_st = TX_BREAK;
                        s_d.tx_out  = 1'b0;
                        s_d.tx_bits = 5'd0;
                        s_d.tx_cnt  = '0;
                        s_d.tx_half = 1'b0;
                    end else if (s_q.tx_pend && !s_q.brkctl[BRK_SEND_BIT]) begin
                        s_d.tx_st    = TX_DATA;
                        s_d.tx_shift = {1'b1, s_q.tx_hold, 1'b0};
                        s_d.tx_pend  = tx_wr;
                        s_d.tx_bits  = 5'd0;
                        s_d.tx_cnt   = '0;
                        s_d.tx_half  = 1'b0;
                    end
                end
                TX_DATA: begin
                    s_d.tx_out = s_q.tx_shift[0];
                    if (base_tick && half_done(s_q.tx_cnt, s_q.div) && s_q.tx_half) begin
                        s_d.tx_shift = {1'b1, s_q.tx_shift[9:1]};
                        s_d.tx_bits  = s_q.tx_bits + 1'b1;
                        if (s_q.tx_bits == 5'(FRAME_BITS - 1)) begin
                            s_d.tx_st  = TX_IDLE;
                            s_d.tx_irq = 1'b1;
                            if (s_q.tx_pend) s_d.tx_cnt = '0;
                        end
                    end
                end
                TX_BREAK: begin
                    s_d.tx_out = 1'b0;
                    if (base_tick && half_done(s_q.tx_cnt, s_q.div) && s_q.tx_half) begin
                        s_d.tx_bits = s_q.tx_bits + 1'b1;
                        if (s_q.tx_bits == brk_len - 1'b1) begin
                            s_d.tx_st  = TX_IDLE;
                            s_d.tx_irq = 1'b1;
                            s_d.tx_out = 1'b1;
                            s_d.brkctl[BRK_SEND_BIT] = 1'b0;
                        end
                    end
                end
                default: s_d.tx_st = TX_IDLE;
            endcase
        end

        // receiver: counter held until a start bit, then one frame
        if (!power || !rxe) begin
            s_d.rx_cnt  = '0;
            s_d.rx_half = 1'b0;
            s_d.rx_st   = RX_IDLE;
            s_d.brkctl[BRK_RXEN_BIT] = 1'b0;
            s_d.brkctl[BRK_FLAG_BIT] = 1'b0;
        end else begin
            if (s_q.rx_st != RX_IDLE && base_tick) begin
                if (half_done(s_q.rx_cnt, s_q.div)) begin
                    s_d.rx_cnt  = '0;
                    s_d.rx_half = ~s_q.rx_half;
                    rx_bit_mid  = 1'b1;
                end else begin
                    s_d.rx_cnt = s_q.rx_cnt + 1'b1;
                end
            end
            unique case (s_q.rx_st)
                RX_IDLE: if (!s_q.filt) begin
                    s_d.rx_st   = RX_START;
                    s_d.rx_cnt  = '0;
                    s_d.rx_half = 1'b0;
                    s_d.rx_low  = 6'd0;
                end
                RX_START: if (rx_bit_mid) begin
                    if (s_q.filt) begin
                        s_d.rx_st = RX_IDLE;  // glitch, not a start bit
                    end else begin
                        s_d.rx_st   = s_q.brkctl[BRK_RXEN_BIT] ? RX_BRK : RX_DATA;
                        s_d.rx_bits = 4'd0;
                        s_d.rx_low  = 6'd1;
                        s_d.rx_half = 1'b0;  // data samples fall mid bit
                    end
                end
                RX_DATA: if (rx_bit_mid && s_q.rx_half) begin
                    s_d.rx_bits = s_q.rx_bits + 1'b1;
                    if (s_q.rx_bits == 4'd8) begin
                        s_d.rx_st  = RX_IDLE;
                        s_d.rx_cnt = '0;
                        if (s_q.rxbuf_full) s_d.err[ERR_OVE_BIT] = 1'b1;
                        else s_d.rxbuf = s_q.rx_shift;
                        s_d.rxbuf_full = 1'b1;
                        if (!s_q.filt) s_d.err[ERR_FE_BIT] = 1'b1;
                        if (s_q.rxbuf_full || !s_q.filt) begin
                            if (s_q.mode[MODE_MERGE_BIT]) s_d.rx_irq = 1'b1;
                            else s_d.err_irq = 1'b1;
                        end else begin
                            s_d.rx_irq = 1'b1;
                        end
                    end else begin
                        s_d.rx_shift = {s_q.filt, s_q.rx_shift[7:1]};
                    end
                end
                RX_BRK: if (rx_bit_mid) begin
                    // count low half bits until the line returns high
                    if (!s_q.filt) begin
                        if (s_q.rx_low != 6'h3F) s_d.rx_low = s_q.rx_low + 1'b1;
                    end else begin
                        s_d.rx_st  = RX_IDLE;
                        s_d.rx_cnt = '0;
                        // still low at half bit 21 means longer than 10.5 bits
                        if (s_q.rx_low >= 6'(BRK_VALID_HALF)) begin
                            s_d.rx_irq = 1'b1;
                            s_d.brkctl[BRK_RXEN_BIT] = 1'b0;
                            s_d.brkctl[BRK_FLAG_BIT] = 1'b0;
                        end
                    end
                end
                default: s_d.rx_st = RX_IDLE;
            endcase
        end
    end

    // single state register; reset clears everything to documented values
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            s_q        <= '0;
            s_q.mode   <= MODE_RST;
            s_q.brkctl <= BRKCTL_RST;
            s_q.cksel  <= CKSEL_RST;
            s_q.div    <= DIV_RST[DIV_WIDTH-1:0];
            s_q.rxbuf  <= RXBUF_RST;
            s_q.pin_sync <= 2'b11;
            s_q.samp   <= 2'b11;
            s_q.filt   <= 1'b1;
            s_q.tx_out <= 1'b1;
            s_q.tx_st  <= TX_IDLE;
            s_q.rx_st  <= RX_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flops; line held high while unpowered
    assign serial_out_pin_o = power ? s_q.tx_out : 1'b1;
    assign tx_done_irq_o    = s_q.tx_irq;
    assign rx_done_irq_o    = s_q.rx_irq;
    assign rx_error_irq_o   = s_q.err_irq;
    assign reg_rdata_o      = s_q.rdata;
endmodule : ubrk_core

// *** ubrk_core_sva.sv ***
// checker: break, interrupt and read-back relations at the core ports
`timescale 1ns/1ps
module ubrk_core_sva
    import ubrk_pkg::*;
(
    // clock and reset
    input wire logic       mclk_i,
    input wire logic       sys_rst_i,
    // register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // serial pins and interrupts
    input wire logic       serial_in_pin_i,
    input wire logic       serial_out_pin_o,
    input wire logic       tx_done_irq_o,
    input wire logic       rx_done_irq_o,
    input wire logic       rx_error_irq_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    localparam int BRK_MIN_LOW = 104;  // 13 bits at the fastest setting, k 4, prescale 0
    logic [7:0]  mode_q;
    logic        brk_tx_q, brk_rx_q, idle_q, clean_q, rd_q;
    logic [3:0]  rd_addr_q;
    logic [15:0] low_cnt_q;
    // shadow of software settings; mirrors the write decode, not the internals
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            mode_q    <= MODE_RST;
            {brk_tx_q, brk_rx_q, idle_q, rd_q} <= 4'h0;
            clean_q   <= 1'b1;
            rd_addr_q <= 4'h0;
            low_cnt_q <= 16'h0000;
        end else begin
            rd_q      <= reg_rd_i;
            rd_addr_q <= reg_addr_i;
            low_cnt_q <= serial_out_pin_o ? 16'h0000 : low_cnt_q + 16'h0001;
            if (reg_wr_i && reg_addr_i == ADDR_MODE) mode_q <= reg_wdata_i;
            if (tx_done_irq_o) brk_tx_q <= 1'b0;
            if (tx_done_irq_o && brk_tx_q) idle_q <= 1'b1;
            if (reg_wr_i && (reg_addr_i == ADDR_TXBUF || reg_addr_i == ADDR_BRKCTL)) idle_q <= 1'b0;
            if (reg_wr_i && reg_addr_i == ADDR_BRKCTL && reg_wdata_i[BRK_SEND_BIT]
                && mode_q[MODE_POWER_BIT] && mode_q[MODE_TXE_BIT]) brk_tx_q <= 1'b1;
            if (rx_done_irq_o) brk_rx_q <= 1'b0;
            if (reg_wr_i && reg_addr_i == ADDR_BRKCTL && reg_wdata_i[BRK_RXEN_BIT]
                && mode_q[MODE_POWER_BIT] && mode_q[MODE_RXE_BIT]) brk_rx_q <= 1'b1;
            // a normal frame or an error ends the untouched-buffer period
            if ((rx_done_irq_o && !brk_rx_q) || rx_error_irq_o) clean_q <= 1'b0;
        end
    end
    chk_merge_route: assert property (mode_q[MODE_MERGE_BIT] |-> !rx_error_irq_o)
        else $error("error interrupt raised while merged");
    chk_irq_apart: assert property (!(rx_done_irq_o && rx_error_irq_o))
        else $error("receive done and error interrupts together");
    chk_unpowered_high: assert property (!mode_q[MODE_POWER_BIT] |-> serial_out_pin_o)
        else $error("output low while unpowered");
    chk_break_min_low: assert property ($rose(serial_out_pin_o) && brk_tx_q |-> low_cnt_q >= BRK_MIN_LOW)
        else $error("break low period too short");
    chk_break_done_irq: assert property ($rose(serial_out_pin_o) && brk_tx_q |-> ##[0:3] tx_done_irq_o)
        else $error("no transmit done after break");
    chk_tx_irq_pulse: assert property (tx_done_irq_o |=> !tx_done_irq_o)
        else $error("transmit done longer than one cycle");
    chk_idle_after_brk: assert property (idle_q && $past(idle_q) |-> serial_out_pin_o)
        else $error("output left idle after break");
    chk_trigger_clear: assert property (idle_q && rd_q && rd_addr_q == ADDR_BRKCTL |-> !reg_rdata_o[BRK_SEND_BIT])
        else $error("break trigger not cleared");
    chk_brk_no_error: assert property (brk_rx_q |-> !rx_error_irq_o)
        else $error("error interrupt in break reception");
    chk_rxbuf_ones: assert property (clean_q && rd_q && rd_addr_q == ADDR_RXBUF |-> reg_rdata_o == 8'hFF)
        else $error("receive buffer changed by break");
endmodule : ubrk_core_sva

bind ubrk_core ubrk_core_sva i_sva (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .serial_in_pin_i(serial_in_pin_i),
    .serial_out_pin_o(serial_out_pin_o), .tx_done_irq_o(tx_done_irq_o), .rx_done_irq_o(rx_done_irq_o),
    .rx_error_irq_o(rx_error_irq_o));

// *** ubrk_node_model.sv ***
// remote serial node: drives the core input line, times the core output lows
`timescale 1ns/1ps
module ubrk_node_model (
    // clock
    input  wire logic   mclk_i,
    // serial lines
    input  wire logic   line_from_dut_i,
    output logic        line_to_dut_o,
    // measurement
    output logic [15:0] low_len_o
);
    logic [15:0] run_q = 16'h0000;
    initial line_to_dut_o = 1'b1;  // bus rests at mark level
    initial low_len_o = 16'h0000;
    // length of the last finished low run on the core output
    always @(posedge mclk_i) begin
        if (!line_from_dut_i) begin
            run_q <= run_q + 16'h0001;
        end else if (run_q != 16'h0000) begin
            low_len_o <= run_q;
            run_q     <= 16'h0000;
        end
    end
    // hold the line low for cyc cycles, then back to mark
    task automatic send_low(input int cyc);
        line_to_dut_o <= 1'b0;
        repeat (cyc) @(posedge mclk_i);
        line_to_dut_o <= 1'b1;
    endtask : send_low
    // one frame, lsb first; a low stop bit makes a framing fault
    task automatic send_byte(input logic [7:0] b, input int bc, input logic stop);
        logic [9:0] f;
        f = {stop, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_to_dut_o <= f[i];
            repeat (bc) @(posedge mclk_i);
        end
        line_to_dut_o <= 1'b1;
    endtask : send_byte
endmodule : ubrk_node_model

// *** uart_break_field_and_baud_generator_tb.sv ***
// testbench: registers, break send, break receive and interrupt routing
`timescale 1ns/1ps
module uart_break_field_and_baud_generator_tb;
    import ubrk_pkg::*;
    logic        mclk_i      = 1'b0;
    logic        sys_rst_i   = 1'b1;
    logic [3:0]  reg_addr_i  = 4'h0;
    logic [7:0]  reg_wdata_i = 8'h00;
    logic        reg_wr_i    = 1'b0;
    logic        reg_rd_i    = 1'b0;
    logic [7:0]  reg_rdata_o, k, b;
    logic        serial_in_pin_i, serial_out_pin_o, tx_done_irq_o, rx_done_irq_o, rx_error_irq_o;
    logic [15:0] low_len;
    int          fail_count  = 0;
    int          checks_done = 0;
    logic [7:0]  rd_exp[$];
    logic [2:0]  irq_exp[$];
    logic        rd_d1 = 1'b0;
    // 25 MHz
    always #20 mclk_i = ~mclk_i;
    ubrk_core i_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .serial_in_pin_i(serial_in_pin_i),
        .serial_out_pin_o(serial_out_pin_o), .tx_done_irq_o(tx_done_irq_o), .rx_done_irq_o(rx_done_irq_o),
        .rx_error_irq_o(rx_error_irq_o));
    ubrk_node_model i_node (.mclk_i(mclk_i), .line_from_dut_i(serial_out_pin_o), .line_to_dut_o(serial_in_pin_i),
        .low_len_o(low_len));
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t ns: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : cmp
    // strobes drop for one cycle between transfers, so no double assignment
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge mclk_i);
        reg_wr_i    <= 1'b0;
        @(posedge mclk_i);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        rd_exp.push_back(e);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge mclk_i);
        reg_rd_i   <= 1'b0;
        @(posedge mclk_i);
    endtask : rd
    task automatic settle(input int n);
        repeat (n) @(posedge mclk_i);
        cmp(16'(irq_exp.size()), 16'h0000, "interrupt missing");
    endtask : settle
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    // read data one cycle after the strobe; each interrupt against the oldest note
    always @(posedge mclk_i) begin
        if (rd_d1) cmp(16'(reg_rdata_o), 16'(rd_exp.pop_front()), "read data");
        rd_d1 = reg_rd_i;
        if (!sys_rst_i && (tx_done_irq_o | rx_done_irq_o | rx_error_irq_o)) begin
            if (irq_exp.size() == 0) cmp(16'({tx_done_irq_o, rx_done_irq_o, rx_error_irq_o}), 16'h0000, "interrupt");
            else cmp(16'({tx_done_irq_o, rx_done_irq_o, rx_error_irq_o}), 16'(irq_exp.pop_front()), "interrupt");
        end
    end
    initial begin
        repeat (12) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        @(posedge mclk_i);
        void'($urandom(99));
        // reset values and an unmapped place
        rd(ADDR_MODE, MODE_RST);
        rd(ADDR_BRKCTL, BRKCTL_RST);
        rd(ADDR_CKSEL, {4'h0, CKSEL_RST});
        rd(ADDR_DIV, DIV_RST);
        rd(ADDR_RXBUF, RXBUF_RST);
        rd(4'hF, 8'h00);
        // power alone: mark level, break trigger refused without transmit enable
        wr(ADDR_MODE, 8'h81);
        cmp(16'(serial_out_pin_o), 16'h0001, "idle level");
        wr(ADDR_BRKCTL, 8'h20);
        rd(ADDR_BRKCTL, 8'h00);
        wr(ADDR_MODE, 8'hE1);
        // every length code, random divider, prescale 0 and 1
        for (int c = 0; c < 8; c++) begin
            k = 8'(4 + $urandom_range(3));
            wr(ADDR_CKSEL, 8'(c % 2));
            wr(ADDR_DIV, k);
            irq_exp.push_back(3'b100);
            wr(ADDR_BRKCTL, 8'(32 + 4 * c));
            settle(40 + (13 + c) * 2 * k * (1 + c % 2));
            cmp(low_len, 16'((13 + c) * 2 * k * (1 + c % 2)), "break low");
            rd(ADDR_BRKCTL, 8'(4 * c));
            repeat (60) @(posedge mclk_i);
            cmp(16'(serial_out_pin_o), 16'h0001, "idle after break");
        end
        // break reception at 8 cycles a bit: 10 bits refused, 11 accepted
        wr(ADDR_CKSEL, 8'h00);
        wr(ADDR_DIV, 8'h04);
        wr(ADDR_BRKCTL, 8'h40);
        rd(ADDR_BRKCTL, 8'hC0);
        i_node.send_low(80);
        settle(60);
        rd(ADDR_BRKCTL, 8'hC0);
        irq_exp.push_back(3'b010);
        i_node.send_low(88);
        settle(60);
        rd(ADDR_ERRSTAT, 8'h00);
        rd(ADDR_BRKCTL, 8'h00);
        rd(ADDR_RXBUF, 8'hFF);
        // good and framing-fault frames under both merge settings
        for (int m = 0; m < 2; m++) begin
            wr(ADDR_MODE, 8'hE0 | 8'(m));
            b = 8'($urandom);
            irq_exp.push_back(3'b010);
            i_node.send_byte(b, 8, 1'b1);
            settle(40);
            rd(ADDR_ERRSTAT, 8'h00);
            rd(ADDR_RXBUF, b);
            irq_exp.push_back(m ? 3'b010 : 3'b001);
            i_node.send_byte(~b, 8, 1'b0);
            settle(40);
            rd(ADDR_ERRSTAT, 8'h04);
            rd(ADDR_RXBUF, ~b);
        end
        wr(ADDR_MODE, 8'h00);
        repeat (8) @(posedge mclk_i);
        cmp(16'(serial_out_pin_o), 16'h0001, "unpowered level");
        cmp(16'(rd_exp.size()), 16'h0000, "reads left");
        tally_and_finish();
    end
    // watchdog well past the planned run
    initial begin
        repeat (40000) @(posedge mclk_i);
        fail_count++;
        tally_and_finish();
    end
endmodule : uart_break_field_and_baud_generator_tb
